// *** include/dfs_defs.svh ***
/*
  Register offsets, field positions, reset values and masks of the drive
  fault/status/command register bank. Assumes inclusion by bare name.
*/
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

`define DFS_BCAST_ADDR 8'h00
`define DFS_OFS_CMD 16'h0001
`define DFS_OFS_FREQ 16'h0002
`define DFS_OFS_CF1 16'h00d0
`define DFS_OFS_CF2 16'h00d1
`define DFS_OFS_OPT 16'h00d8
`define DFS_OFS_CUR 16'h00fb
`define DFS_OFS_LOG 16'h00e0

`define DFS_CMD_RST 16'h0000
`define DFS_FREQ_RST 16'h0000
`define DFS_CMD_MASK 16'h7033

`define DFS_CMD_RUN 0
`define DFS_CMD_REV 1
`define DFS_CMD_EXTF 4
`define DFS_CMD_FRST 5
`define DFS_CMD_MFI5 12
`define DFS_CMD_MFI6 13
`define DFS_CMD_MFI7 14

`define DFS_CF1_MASK 16'h79cc
`define DFS_CF2_MASK 16'h03ff
`define DFS_OPT_MASK 16'h001b

`define DFS_CF1_ADC 2
`define DFS_CF1_PWM 3
`define DFS_CF1_SPEC 6
`define DFS_CF1_TBL 7
`define DFS_CF1_EEP 8
`define DFS_CF1_RAM 11
`define DFS_CF1_FLASH 12
`define DFS_CF1_WDT 13
`define DFS_CF1_CTLA 14

`define DFS_CF2_CLK 0
`define DFS_CF2_TIM 1
`define DFS_CF2_CTLB 2
`define DFS_CF2_CTLC 3
`define DFS_CF2_PWRUP 4
`define DFS_CF2_COMMUP 5
`define DFS_CF2_ADC 6
`define DFS_CF2_PWMFB 7
`define DFS_CF2_CAP 8
`define DFS_CF2_TBA 9

`define DFS_OPT_COMPAT 0
`define DFS_OPT_UNCON 1
`define DFS_OPT_SELF 3
`define DFS_OPT_FLASH 4

`define DFS_CUR_DIV 16'h000a

`endif

// *** include/dfs_pkg.sv ***
/*
  Types shared by the drive register bank.
  Assumes nothing of its surroundings.
*/
package dfs_pkg;
  typedef enum logic [1:0] {
    dfs_rsp_ok,
    dfs_rsp_bad_addr,
    dfs_rsp_none
  } dfs_rsp_t;
endpackage

// *** src/dfs_fault_word.sv ***
/*
  One sticky fault status word: bits set by fault events, cleared by a
  fault reset, reserved positions forced to zero.
  Assumes events synchronous to core_clk.
*/
`timescale 1ns/1ps
module dfs_fault_word #(
  parameter int WIDTH = 16,
  parameter logic [15:0] USED_MASK = 16'hffff
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] events,
  input wire logic clear,
  output logic [WIDTH-1:0] word_q
);
  logic [WIDTH-1:0] word_d;

  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("fault word must be 16 bits wide");
    end
  endgenerate

  // set wins over clear so no fault is lost in the reset cycle
  always_comb begin
    word_d = ((clear ? '0 : word_q) | events) & USED_MASK[WIDTH-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end
endmodule // dfs_fault_word

// *** src/dfs_current_scale.sv ***
/*
  Output current monitor scaling: raw value in 0.01 A, reported in 0.01 A
  or, on large ratings, 0.1 A.
  Assumes large_rating is static during operation.
*/
`timescale 1ns/1ps
`include "dfs_defs.svh"
module dfs_current_scale (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] current_centiamp,
  input wire logic large_rating,
  output logic [15:0] current_q
);
  logic [15:0] current_d;

  // constant divide; one cycle of latency is irrelevant for a monitor
  always_comb begin
    current_d = large_rating ? (current_centiamp / `DFS_CUR_DIV) : current_centiamp;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      current_q <= 16'h0000;
    end else begin
      current_q <= current_d;
    end
  end
endmodule // dfs_current_scale

// *** src/dfs_regs.sv ***
/*
  Drive fault/status/command register bank, reached by decoded messages of
  the serial slave link (slave address, register number, read or write).
  A fault reset, the 0-to-1 write of command bit five, clears the three
  fault words and the error log one cycle after the write is taken.
  Broadcast reads are dropped without an answer or any effect.
  Command outputs follow the stored word one cycle later; the three multi-function inputs also need their mfi_enable bit set.
  Assumes the link layer delivers one message per req_valid pulse and that
  the multi-function input enable register lives outside and arrives as
  mfi_enable.
*/
`timescale 1ns/1ps
`include "dfs_defs.svh"
module dfs_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] own_slave_addr,
  input wire logic req_valid,
  input wire logic [7:0] req_slave_addr,
  input wire logic req_write,
  input wire logic [15:0] req_reg_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [15:0] mfi_enable,
  input wire logic comm_err_event,
  input wire logic large_rating,
  input wire logic [15:0] current_centiamp,
  input wire logic adc_error_flag,
  input wire logic pwm_data_fault_flag,
  input wire logic board_spec_mismatch_flag,
  input wire logic terminal_board_link_fault,
  input wire logic eeprom_link_fault,
  input wire logic ram_fault_flag,
  input wire logic flash_fault_flag,
  input wire logic watchdog_exception_flag,
  input wire logic control_circuit_fault_a,
  input wire logic clock_fault_flag,
  input wire logic timing_fault_flag,
  input wire logic control_circuit_fault_b,
  input wire logic control_circuit_fault_c,
  input wire logic powerup_hw_fault,
  input wire logic comm_startup_hw_fault,
  input wire logic adc_fault_flag,
  input wire logic pwm_feedback_fault,
  input wire logic capacity_signal_fault,
  input wire logic terminal_board_absent,
  input wire logic option_compat_error,
  input wire logic option_unconnected,
  input wire logic option_selftest_error,
  input wire logic option_flash_mode_error,
  output logic rsp_valid_q,
  output logic [15:0] rsp_data_q,
  output logic rsp_err_q,
  output logic run_cmd_q,
  output logic reverse_cmd_q,
  output logic ext_fault_cmd_q,
  output logic fault_reset_q,
  output logic multifunction_input_five_q,
  output logic multifunction_input_six_q,
  output logic multifunction_input_seven_q,
  output logic [15:0] freq_ref_q,
  output logic comm_err_log_q
);
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [15:0] freq_d;
  logic log_d;
  logic fault_reset_d;
  logic rsp_valid_d;
  logic [15:0] rsp_data_d;
  logic rsp_err_d;
  logic run_d;
  logic rev_d;
  logic extf_d;
  logic mfi5_d;
  logic mfi6_d;
  logic mfi7_d;
  // raw event maps and their sticky copies
  logic [15:0] cf1_ev;
  logic [15:0] cf2_ev;
  logic [15:0] opt_ev;
  logic [15:0] cf1_q;
  logic [15:0] cf2_q;
  logic [15:0] opt_q;
  logic [15:0] cur_q;
  // decoded message kinds
  logic addressed;
  logic bcast;
  logic wr_cmd;
  logic wr_freq;
  dfs_pkg::dfs_rsp_t rsp_kind;

  always_comb begin
    cf1_ev = 16'h0000;
    cf1_ev[`DFS_CF1_ADC] = adc_error_flag;
    cf1_ev[`DFS_CF1_PWM] = pwm_data_fault_flag;
    cf1_ev[`DFS_CF1_SPEC] = board_spec_mismatch_flag;
    cf1_ev[`DFS_CF1_TBL] = terminal_board_link_fault;
    cf1_ev[`DFS_CF1_EEP] = eeprom_link_fault;
    cf1_ev[`DFS_CF1_RAM] = ram_fault_flag;
    cf1_ev[`DFS_CF1_FLASH] = flash_fault_flag;
    cf1_ev[`DFS_CF1_WDT] = watchdog_exception_flag;
    cf1_ev[`DFS_CF1_CTLA] = control_circuit_fault_a;
  end

  // clock, timing, two control-path, two startup, ADC, PWM feedback, capacity and terminal board faults
  always_comb begin
    cf2_ev = 16'h0000;
    cf2_ev[`DFS_CF2_CLK] = clock_fault_flag;
    cf2_ev[`DFS_CF2_TIM] = timing_fault_flag;
    cf2_ev[`DFS_CF2_CTLB] = control_circuit_fault_b;
    cf2_ev[`DFS_CF2_CTLC] = control_circuit_fault_c;
    cf2_ev[`DFS_CF2_PWRUP] = powerup_hw_fault;
    cf2_ev[`DFS_CF2_COMMUP] = comm_startup_hw_fault;
    cf2_ev[`DFS_CF2_ADC] = adc_fault_flag;
    cf2_ev[`DFS_CF2_PWMFB] = pwm_feedback_fault;
    cf2_ev[`DFS_CF2_CAP] = capacity_signal_fault;
    cf2_ev[`DFS_CF2_TBA] = terminal_board_absent;
  end

  // option card map, bit 2 unused
  always_comb begin
    opt_ev = 16'h0000;
    opt_ev[`DFS_OPT_COMPAT] = option_compat_error;
    opt_ev[`DFS_OPT_UNCON] = option_unconnected;
    opt_ev[`DFS_OPT_SELF] = option_selftest_error;
    opt_ev[`DFS_OPT_FLASH] = option_flash_mode_error;
  end

  dfs_fault_word #(.WIDTH(16), .USED_MASK(`DFS_CF1_MASK)) u_cf1 (
    .core_clk(core_clk),
    .rstn(rstn),
    .events(cf1_ev),
    .clear(fault_reset_q),
    .word_q(cf1_q)
  );

  // all three words clear on the registered fault reset pulse
  dfs_fault_word #(.WIDTH(16), .USED_MASK(`DFS_CF2_MASK)) u_cf2 (
    .core_clk(core_clk),
    .rstn(rstn),
    .events(cf2_ev),
    .clear(fault_reset_q),
    .word_q(cf2_q)
  );

  dfs_fault_word #(.WIDTH(16), .USED_MASK(`DFS_OPT_MASK)) u_opt (
    .core_clk(core_clk),
    .rstn(rstn),
    .events(opt_ev),
    .clear(fault_reset_q),
    .word_q(opt_q)
  );

  // unit chosen by rating
  // scaling sits in its own flop; the extra cycle is harmless for a monitor
  dfs_current_scale u_cur (
    .core_clk(core_clk),
    .rstn(rstn),
    .current_centiamp(current_centiamp),
    .large_rating(large_rating),
    .current_q(cur_q)
  );

  // message decode and register writes
  always_comb begin
    bcast = req_valid && (req_slave_addr == `DFS_BCAST_ADDR);
    // an own address of zero would alias broadcast, so it never answers
    addressed = req_valid && (req_slave_addr == own_slave_addr) && !bcast;
    wr_cmd = (addressed || bcast) && req_write && (req_reg_addr == `DFS_OFS_CMD);
    wr_freq = (addressed || bcast) && req_write && (req_reg_addr == `DFS_OFS_FREQ);
    cmd_d = cmd_q;
    freq_d = freq_ref_q;
    // reserved command bits are never stored, so they read back zero
    if (wr_cmd) begin
      cmd_d = req_wdata & `DFS_CMD_MASK;
    end
    if (wr_freq) begin
      freq_d = req_wdata;
    end
    // reset request on rising bit five
    fault_reset_d = wr_cmd && req_wdata[`DFS_CMD_FRST] && !cmd_q[`DFS_CMD_FRST];
    // log sticky, only fault reset clears
    log_d = comm_err_event || (comm_err_log_q && !fault_reset_q);
  end

  // command outputs
  // enable gating applies every cycle, so a later enable change takes effect
  always_comb begin
    run_d = cmd_q[`DFS_CMD_RUN];
    rev_d = cmd_q[`DFS_CMD_REV];
    extf_d = cmd_q[`DFS_CMD_EXTF];
    mfi5_d = cmd_q[`DFS_CMD_MFI5] && mfi_enable[`DFS_CMD_MFI5];
    mfi6_d = cmd_q[`DFS_CMD_MFI6] && mfi_enable[`DFS_CMD_MFI6];
    mfi7_d = cmd_q[`DFS_CMD_MFI7] && mfi_enable[`DFS_CMD_MFI7];
  end

  // answer path
  always_comb begin
    // data stays zero on writes and errors so stale words never leak
    rsp_kind = dfs_pkg::dfs_rsp_ok;
    rsp_data_d = 16'h0000;
    if (!addressed) begin
      rsp_kind = dfs_pkg::dfs_rsp_none;
    end else if (!req_write) begin
      case (req_reg_addr)
        `DFS_OFS_CMD: rsp_data_d = cmd_q;
        `DFS_OFS_FREQ: rsp_data_d = freq_ref_q;
        `DFS_OFS_CF1: rsp_data_d = cf1_q;
        `DFS_OFS_CF2: rsp_data_d = cf2_q;
        `DFS_OFS_OPT: rsp_data_d = opt_q;
        `DFS_OFS_CUR: rsp_data_d = cur_q;
        `DFS_OFS_LOG: rsp_data_d = {15'h0000, comm_err_log_q};
        default: rsp_kind = dfs_pkg::dfs_rsp_bad_addr;
      endcase
    end else begin
      // writes to status words acknowledged, not stored
      // answering ok lets a block write run on past the status words
      case (req_reg_addr)
        `DFS_OFS_CMD,
        `DFS_OFS_FREQ,
        `DFS_OFS_CF1,
        `DFS_OFS_CF2,
        `DFS_OFS_OPT,
        `DFS_OFS_CUR,
        `DFS_OFS_LOG: rsp_kind = dfs_pkg::dfs_rsp_ok;
        default: rsp_kind = dfs_pkg::dfs_rsp_bad_addr;
      endcase
    end
    rsp_valid_d = (rsp_kind != dfs_pkg::dfs_rsp_none);
    rsp_err_d = (rsp_kind == dfs_pkg::dfs_rsp_bad_addr);
  end

  // command and frequency registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_q <= `DFS_CMD_RST;
      freq_ref_q <= `DFS_FREQ_RST;
    end else begin
      cmd_q <= cmd_d;
      freq_ref_q <= freq_d;
    end
  end

  // reset pulse and sticky error log
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fault_reset_q <= 1'b0;
      comm_err_log_q <= 1'b0;
    end else begin
      fault_reset_q <= fault_reset_d;
      comm_err_log_q <= log_d;
    end
  end

  // answer frame registers, one cycle each
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      rsp_err_q <= rsp_err_d;
    end
  end

  // command outputs registered so every pin comes from a flop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_cmd_q <= 1'b0;
      reverse_cmd_q <= 1'b0;
      ext_fault_cmd_q <= 1'b0;
      multifunction_input_five_q <= 1'b0;
      multifunction_input_six_q <= 1'b0;
      multifunction_input_seven_q <= 1'b0;
    end else begin
      run_cmd_q <= run_d;
      reverse_cmd_q <= rev_d;
      ext_fault_cmd_q <= extf_d;
      multifunction_input_five_q <= mfi5_d;
      multifunction_input_six_q <= mfi6_d;
      multifunction_input_seven_q <= mfi7_d;
    end
  end
endmodule // dfs_regs

// *** tb/dfs_regs_properties.sv ***
/* Port checker of the drive register bank.
   Assumes binding to dfs_regs, single clock domain. */
`timescale 1ns/1ps
module dfs_regs_properties (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] own_slave_addr,
  input wire logic req_valid,
  input wire logic [7:0] req_slave_addr,
  input wire logic req_write,
  input wire logic [15:0] req_reg_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [15:0] mfi_enable,
  input wire logic rsp_valid_q,
  input wire logic [15:0] rsp_data_q,
  input wire logic run_cmd_q,
  input wire logic fault_reset_q,
  input wire logic multifunction_input_five_q,
  input wire logic [15:0] freq_ref_q,
  input wire logic comm_err_log_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic hit = req_valid && req_slave_addr == own_slave_addr;
  wire logic bc = req_valid && req_slave_addr == 8'h00;
  wire logic cw = (hit || bc) && req_write;
  bcast_silent_a: assert property (bc |=> !rsp_valid_q)
    else $error("broadcast answered");
  own_answer_a: assert property (hit |=> rsp_valid_q)
    else $error("addressed message not answered");
  answer_cause_a: assert property (rsp_valid_q |-> $past(hit))
    else $error("answer without addressed message");
  resv_zero_a: assert property (hit && !req_write && req_reg_addr == 16'h00d0 |=> (rsp_data_q & 16'h8633) == 16'h0000)
    else $error("reserved fault bit set");
  run_follow_a: assert property (cw && req_reg_addr == 16'h0001 |=> ##1 run_cmd_q == $past(req_wdata[0], 2))
    else $error("run output wrong");
  reset_pulse_a: assert property (fault_reset_q |=> !fault_reset_q)
    else $error("fault reset longer than a cycle");
  reset_cause_a: assert property (fault_reset_q |-> $past(cw && req_reg_addr == 16'h0001 && req_wdata[5]))
    else $error("fault reset without command");
  input_gate_a: assert property (multifunction_input_five_q |-> $past(mfi_enable[12]))
    else $error("input five not gated");
  log_keep_a: assert property (comm_err_log_q && !fault_reset_q |=> comm_err_log_q)
    else $error("error log lost");
  freq_write_a: assert property (cw && req_reg_addr == 16'h0002 |=> freq_ref_q == $past(req_wdata))
    else $error("frequency not written");
  cover property (bc && req_write);
  cover property (fault_reset_q);
  cover property (multifunction_input_five_q);
endmodule // dfs_regs_properties

bind dfs_regs dfs_regs_properties u_chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .own_slave_addr(own_slave_addr),
  .req_valid(req_valid),
  .req_slave_addr(req_slave_addr),
  .req_write(req_write),
  .req_reg_addr(req_reg_addr),
  .req_wdata(req_wdata),
  .mfi_enable(mfi_enable),
  .rsp_valid_q(rsp_valid_q),
  .rsp_data_q(rsp_data_q),
  .run_cmd_q(run_cmd_q),
  .fault_reset_q(fault_reset_q),
  .multifunction_input_five_q(multifunction_input_five_q),
  .freq_ref_q(freq_ref_q),
  .comm_err_log_q(comm_err_log_q)
);

// *** tb/dfs_master.sv ***
/* Link master model handing decoded messages to the bank.
   Assumes calls start at or just after a clock edge. */
`timescale 1ns/1ps
module dfs_master (
  input wire logic core_clk,
  output logic req_valid,
  output logic [7:0] req_slave_addr,
  output logic req_write,
  output logic [15:0] req_reg_addr,
  output logic [15:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_slave_addr = 8'h5a;
    req_write = 1'b0;
    req_reg_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  task send(input logic [7:0] sa, input logic wr, input logic [15:0] ra, input logic [15:0] wd);
    req_valid <= 1'b1;
    req_slave_addr <= sa;
    req_write <= wr;
    req_reg_addr <= ra;
    req_wdata <= wd;
    @(posedge core_clk);
  endtask
  // released write, register and data lines flip, so stale values never pass; the slave address is held
  task idle();
    req_valid <= 1'b0;
    req_write <= ~req_write;
    req_reg_addr <= ~req_reg_addr;
    req_wdata <= ~req_wdata;
    @(posedge core_clk);
  endtask
endmodule // dfs_master

// *** tb/dfs_regs_bench.sv ***
/* Self-checking bench of the drive register bank.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module dfs_regs_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] own_slave_addr = 8'h11;
  logic req_valid, req_write, rsp_valid_q, rsp_err_q, run_cmd_q, reverse_cmd_q, ext_fault_cmd_q, fault_reset_q;
  logic [7:0] req_slave_addr;
  logic [15:0] req_reg_addr, req_wdata, rsp_data_q, freq_ref_q, e1, e2, eo, d, m;
  logic [15:0] mfi_enable = 16'h0000, current_centiamp = 16'h0000, f1 = 16'h0000, f2 = 16'h0000, fo = 16'h0000;
  logic [15:0] cmd_m = 16'h0000;
  logic comm_err_event = 1'b0, large_rating = 1'b0, comm_err_log_q;
  logic multifunction_input_five_q, multifunction_input_six_q, multifunction_input_seven_q;
  int seed = 32'h5a38e189;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  dfs_master u_mst (.core_clk(core_clk), .req_valid(req_valid), .req_slave_addr(req_slave_addr),
    .req_write(req_write), .req_reg_addr(req_reg_addr), .req_wdata(req_wdata));
  dfs_regs u_dut (.core_clk(core_clk), .rstn(rstn), .own_slave_addr(own_slave_addr), .req_valid(req_valid),
    .req_slave_addr(req_slave_addr), .req_write(req_write), .req_reg_addr(req_reg_addr), .req_wdata(req_wdata),
    .mfi_enable(mfi_enable), .comm_err_event(comm_err_event), .large_rating(large_rating),
    .current_centiamp(current_centiamp), .adc_error_flag(f1[2]), .pwm_data_fault_flag(f1[3]),
    .board_spec_mismatch_flag(f1[6]),
    .terminal_board_link_fault(f1[7]), .eeprom_link_fault(f1[8]), .ram_fault_flag(f1[11]), .flash_fault_flag(f1[12]),
    .watchdog_exception_flag(f1[13]), .control_circuit_fault_a(f1[14]), .clock_fault_flag(f2[0]),
    .timing_fault_flag(f2[1]), .control_circuit_fault_b(f2[2]), .control_circuit_fault_c(f2[3]),
    .powerup_hw_fault(f2[4]), .comm_startup_hw_fault(f2[5]), .adc_fault_flag(f2[6]), .pwm_feedback_fault(f2[7]),
    .capacity_signal_fault(f2[8]), .terminal_board_absent(f2[9]), .option_compat_error(fo[0]),
    .option_unconnected(fo[1]), .option_selftest_error(fo[3]), .option_flash_mode_error(fo[4]),
    .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .rsp_err_q(rsp_err_q), .run_cmd_q(run_cmd_q),
    .reverse_cmd_q(reverse_cmd_q), .ext_fault_cmd_q(ext_fault_cmd_q), .fault_reset_q(fault_reset_q),
    .multifunction_input_five_q(multifunction_input_five_q),
    .multifunction_input_six_q(multifunction_input_six_q),
    .multifunction_input_seven_q(multifunction_input_seven_q), .freq_ref_q(freq_ref_q),
    .comm_err_log_q(comm_err_log_q));
  task results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] cur(input logic [15:0] c, input logic lg);
    return lg ? c / 16'h000a : c;
  endfunction
  task rd(input logic [15:0] ra, input logic [15:0] exp, input logic ee);
    u_mst.send(own_slave_addr, 1'b0, ra, 16'h0000);
    // the answer stands for one cycle only: look while the master idles
    fork
      u_mst.idle();
      begin
        #1;
        chk({14'h0000, rsp_valid_q, rsp_err_q}, {14'h0000, 1'b1, ee});
        chk(rsp_data_q, exp);
      end
    join
  endtask
  task wr(input logic [7:0] sa, input logic [15:0] ra, input logic [15:0] wd);
    logic go;
    go = (sa == own_slave_addr || sa == 8'h00) && ra == 16'h0001;
    u_mst.send(sa, 1'b1, ra, wd);
    fork
      u_mst.idle();
      begin
        #1;
        chk({15'h0000, rsp_valid_q}, {15'h0000, sa == own_slave_addr});
        chk({15'h0000, fault_reset_q}, {15'h0000, go && wd[5] && !cmd_m[5]});
      end
    join
    if (go) begin
      cmd_m = wd & 16'h7033;
    end
    @(posedge core_clk);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(16'h00d0, 16'h0000, 1'b0);
    e1 = 16'h0000;
    e2 = 16'h0000;
    eo = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed) & $random(seed) & $random(seed));
      f1 <= d;
      f2 <= {d[7:0], d[15:8]};
      fo <= ~d;
      e1 |= d & 16'h79cc;
      e2 |= {d[7:0], d[15:8]} & 16'h03ff;
      eo |= ~d & 16'h001b;
      @(posedge core_clk);
    end
    f1 <= 16'h0000;
    f2 <= 16'h0000;
    fo <= 16'h0000;
    repeat (2) @(posedge core_clk);
    rd(16'h00d0, e1, 1'b0);
    rd(16'h00d1, e2, 1'b0);
    rd(16'h00d8, eo, 1'b0);
    wr(own_slave_addr, 16'h00d0, 16'hffff);
    rd(16'h00d0, e1, 1'b0);
    comm_err_event <= 1'b1;
    @(posedge core_clk);
    comm_err_event <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk({15'h0000, comm_err_log_q}, 16'h0001);
    rd(16'h00e0, 16'h0001, 1'b0);
    mfi_enable <= 16'h7000;
    wr(8'h00, 16'h0001, 16'h7021);
    chk({12'h000, run_cmd_q, multifunction_input_five_q, multifunction_input_six_q, multifunction_input_seven_q},
      16'h000f);
    rd(16'h00d1, 16'h0000, 1'b0);
    rd(16'h00e0, 16'h0000, 1'b0);
    chk({15'h0000, comm_err_log_q}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      m = 16'($random(seed));
      mfi_enable <= m;
      wr(own_slave_addr, 16'h0001, d);
      chk({10'h000, run_cmd_q, reverse_cmd_q, ext_fault_cmd_q, multifunction_input_seven_q,
        multifunction_input_six_q, multifunction_input_five_q}, {10'h000, d[0], d[1], d[4], d[14:12] & m[14:12]});
      rd(16'h0001, d & 16'h7033, 1'b0);
    end
    wr(8'h22, 16'h0001, ~d);
    rd(16'h0001, d & 16'h7033, 1'b0);
    d = 16'($random(seed));
    wr(8'h00, 16'h0002, d);
    chk(freq_ref_q, d);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      current_centiamp <= d;
      large_rating <= i[0];
      repeat (2) @(posedge core_clk);
      rd(16'h00fb, cur(d, i[0]), 1'b0);
    end
    rd(16'h0003, 16'h0000, 1'b1);
    results();
  end
endmodule // dfs_regs_bench
